// file: bench/timer_waveform_mode_control_tb.sv
// Testbench for the timer block: registers, waveforms and interrupt.
// Assumes the pin models stand on both compare outputs.
`timescale 1ns/1ns
module timer_waveform_mode_control_tb;
    reg          i_clock = 0, i_nrst = 0, cyc = 0, stb = 0, we = 0;
    reg  [7:0]   adr = 8'h00, r = 8'h00;
    reg  [3:0]   sel = 4'h0;
    reg  [31:0]  wdat = 32'h0;
    reg  [1:0]   dir = 2'h3, port = 2'h0;
    wire [31:0]  rdat;
    wire         ack, irq, out_a, out_b, ovr_a, ovr_b, pin_a, pin_b;
    logic [31:0] q;
    int          n_errors = 0, tests_run = 0, hi, hb, ta, tb, n;
    always #50 i_clock = ~i_clock;
    twm_timer dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_cyc(cyc),
        .i_stb(stb), .i_we(we), .i_adr(adr), .i_sel(sel), .i_dat(wdat),
        .o_dat(rdat), .o_ack(ack), .o_irq(irq), .o_compare_output_a(out_a),
        .o_compare_output_b(out_b), .o_pin_override_a(ovr_a),
        .o_pin_override_b(ovr_b));
    twm_pin_load pla (.i_override(ovr_a), .i_wave(out_a), .i_port(port[0]),
        .i_dir(dir[0]), .o_pin(pin_a));
    twm_pin_load plb (.i_override(ovr_b), .i_wave(out_b), .i_port(port[1]),
        .i_dir(dir[1]), .o_pin(pin_b));
    function automatic logic [7:0] ctrl_view(input logic [7:0] v);
        return v & 8'hf3;
    endfunction
    task summarize;
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task bus(input bit w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge i_clock);
        {cyc, stb, we, sel} <= {2'b11, w, 4'h1};
        adr <= a;
        wdat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k == 20) begin
            n_errors++;
            summarize();
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task run(input logic [2:0] m, input logic [3:0] com,
             input logic [7:0] a, b, input int c, ehi, eta, ehb, etb);
        logic pa, pb;
        bus(1, 8'hcc, {4'h0, m[2], 3'h0});
        bus(1, 8'ha4, a);
        bus(1, 8'ha0, b);
        bus(1, 8'ha8, {com, 2'h0, m[1:0]});
        repeat (600) @(posedge i_clock);
        {hi, hb, ta, tb, pa, pb} = {128'h0, out_a, out_b};
        repeat (c) begin
            @(posedge i_clock);
            hi += out_a;
            hb += out_b;
            ta += (out_a != pa);
            tb += (out_b != pb);
            {pa, pb} = {out_a, out_b};
        end
        if (ehi >= 0) check("high_a", ehi, hi);
        if (ehb >= 0) check("high_b", ehb, hb);
        check("toggle_a", eta, ta);
        check("toggle_b", etb, tb);
        check("pin_a", out_a, pin_a);
    endtask
    initial begin
        #4000000;
        n_errors++;
        summarize();
    end
    initial begin
        void'($urandom(78326));
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        bus(0, 8'ha8, 0);
        check("ctrl_a", 0, q);
        for (n = 0; n < 16; n++) begin
            r = $urandom;
            bus(1, 8'ha8, {n[3:0], r[3:0]});
            bus(0, 8'ha8, 0);
            check("ctrl_a", ctrl_view({n[3:0], r[3:0]}), q);
            check("ovr_a", |n[3:2], ovr_a);
            check("ovr_b", |n[1:0], ovr_b);
        end
        bus(1, 8'hcc, 8'hff);
        bus(0, 8'hcc, 0);
        check("ctrl_b", 8'h08, q);
        bus(1, 8'h04, 8'hff);
        bus(0, 8'h04, 0);
        check("unmapped", 0, q);
        bus(1, 8'ha8, 8'h00);
        bus(1, 8'hcc, 8'h00);
        bus(1, 8'hc8, 8'h10);
        bus(1, 8'he4, 8'h01);
        repeat (250) @(posedge i_clock);
        check("irq", 1, irq);
        bus(0, 8'he0, 0);
        check("overflow", 1, q[0]);
        repeat (2) @(posedge i_clock);
        check("irq_clear", 0, irq);
        bus(1, 8'he4, 8'h00);
        repeat (300) @(posedge i_clock);
        check("irq_masked", 0, irq);
        r = 8'd4 + ($urandom % 28);
        run(0, 4'b0101, $urandom, $urandom, 512, -1, 2, -1, 2);
        run(0, 4'b1011, $urandom, $urandom, 512, 0, 0, 512, 0);
        run(2, 4'b0101, r, r >> 1, 8 * (r + 1), -1, 8, -1, 8);
        run(3, 4'b1011, 63, 191, 256, 64, 2, 64, 2);
        run(3, 4'b0100, 63, 0, 256, -1, 0, -1, 0);
        run(7, 4'b0110, 20, 5, 42, -1, 2, 12, 4);
        run(7, 4'b1011, 20, 20, 42, 42, 0, 0, 0);
        run(1, 4'b1011, 64, 64, 510, 128, 2, 382, 2);
        run(5, 4'b0110, 100, 50, 400, -1, 2, 200, 4);
        summarize();
    end
endmodule

// file: bench/twm_pin_load.sv
// Pin model: the external load seen by one compare output pin.
// Assumes the bench drives the pin direction and the port data.
`timescale 1ns/1ns
module twm_pin_load (
    input  wire i_override,
    input  wire i_wave,
    input  wire i_port,
    input  wire i_dir,
    output wire o_pin
);
    // A pin left as input is pulled up by the load, never the last value.
    assign o_pin = !i_dir ? 1'b1
                 : i_override ? i_wave : i_port;
endmodule

// file: bench/twm_timer_properties.sv
// Port checker for the timer block: bus handshake and control fields.
// Assumes one clock domain and the active low asynchronous reset.
`timescale 1ns/1ns
module twm_timer_properties (
    input wire        i_clock,
    input wire        i_nrst,
    input wire        i_cyc,
    input wire        i_stb,
    input wire        i_we,
    input wire [7:0]  i_adr,
    input wire [3:0]  i_sel,
    input wire [31:0] i_dat,
    input wire [31:0] o_dat,
    input wire        o_ack,
    input wire        o_pin_override_a,
    input wire        o_pin_override_b
);
    wire      req = i_cyc && i_stb;
    wire      wr_a = req && i_we && i_sel[0] && i_adr == 8'ha8;
    reg [7:0] shadow;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            shadow <= 8'h00;
        else if (wr_a && o_ack)
            shadow <= i_dat[7:0] & 8'hf3;
    end
    chk_ack_pulse: assert property (o_ack |=> !o_ack)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (req && !o_ack |=> o_ack)
        else $error("request not answered next cycle");
    chk_ack_cause: assert property (!req |=> !o_ack)
        else $error("ack without request");
    chk_dat_idle: assert property (!o_ack |-> o_dat == 32'h0)
        else $error("read data outside ack");
    chk_ctrl_readback: assert property (
        o_ack && req && !i_we && i_adr == 8'ha8 |-> o_dat == {24'h0, shadow})
        else $error("control read differs from written value");
    chk_override_a: assert property (wr_a && o_ack |=>
        o_pin_override_a == ($past(i_dat[7:6]) != 2'h0))
        else $error("override a not set by field");
    chk_override_b: assert property (wr_a && o_ack |=>
        o_pin_override_b == ($past(i_dat[5:4]) != 2'h0))
        else $error("override b not set by field");
    chk_ovr_cause: assert property ($changed(o_pin_override_a) ||
        $changed(o_pin_override_b) |-> $past(wr_a) || $past(wr_a, 2))
        else $error("override changed without control write");
endmodule
bind twm_timer twm_timer_properties u_props (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_cyc(i_cyc), .i_stb(i_stb), .i_we(i_we),
    .i_adr(i_adr), .i_sel(i_sel), .i_dat(i_dat), .o_dat(o_dat),
    .o_ack(o_ack), .o_pin_override_a(o_pin_override_a),
    .o_pin_override_b(o_pin_override_b));

// file: core/twm_defs.vh
// Constants for the timer waveform and compare output control block.
// Assumes a Wishbone classic slave with 8-bit registers in word slots.
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH
`define TWM_ADR_CTRL_A    6'h2a
`define TWM_ADR_CTRL_B    6'h33
`define TWM_ADR_CNT       6'h32
`define TWM_ADR_CMP_A     6'h29
`define TWM_ADR_CMP_B     6'h28
`define TWM_ADR_STATUS    6'h38
`define TWM_ADR_MASK      6'h39
`define TWM_CTRL_A_MASK   8'hf3
`define TWM_CTRL_B_MASK   8'h08
`define TWM_WGM_HIGH_BIT  3
`define TWM_MAX           8'hff
`define TWM_BOTTOM        8'h00
`define TWM_RESET_VAL     8'h00
`define TWM_ST_OVF        0
`define TWM_ST_CMPA       1
`define TWM_ST_CMPB       2
`define TWM_TYPE_NORMAL   2'h0
`define TWM_TYPE_CTC      2'h1
`define TWM_TYPE_FAST     2'h2
`define TWM_TYPE_PHASE    2'h3
`endif

// file: core/twm_timer.v
// Timer/counter 0 waveform generator with compare outputs.
// Assumes a Wishbone classic master on the same clock; the pins go to port
// logic that applies the pin direction set by software.
`timescale 1ns/1ns
`include "twm_defs.vh"
module twm_timer (
    input  wire       i_clock,
    input  wire       i_nrst,
    input  wire       i_cyc,
    input  wire       i_stb,
    input  wire       i_we,
    input  wire [7:0] i_adr,
    input  wire [3:0] i_sel,
    input  wire [31:0] i_dat,
    output wire [31:0] o_dat,
    output wire       o_ack,
    output reg        o_irq,
    output reg        o_compare_output_a,
    output reg        o_compare_output_b,
    output reg        o_pin_override_a,
    output reg        o_pin_override_b
);
    localparam ST_UP   = 1'b0;
    localparam ST_DOWN = 1'b1;

    reg  [7:0] ctrl_a;
    reg        wave_gen_mode_high;
    reg  [7:0] count;
    reg  [7:0] compare_value_a;
    reg  [7:0] compare_value_b;
    reg  [7:0] buf_cmp_a;
    reg  [7:0] buf_cmp_b;
    reg  [2:0] status;
    reg  [2:0] mask;
    reg        dir;
    reg        ack;
    reg  [31:0] rdat;

    wire [1:0] cmp_out_mode_a = ctrl_a[7:6];
    wire [1:0] cmp_out_mode_b = ctrl_a[5:4];
    wire [1:0] wave_gen_mode_low = ctrl_a[1:0];
    // Mode is assembled from both control registers.
    wire [2:0] wave_gen_mode = {wave_gen_mode_high,
                                wave_gen_mode_low};

    // Classify the mode; reserved values behave as normal counting.
    function [1:0] wave_type;
        input [2:0] m;
        begin
            case (m)
                3'h1, 3'h5: wave_type = `TWM_TYPE_PHASE;
                3'h2:       wave_type = `TWM_TYPE_CTC;
                3'h3, 3'h7: wave_type = `TWM_TYPE_FAST;
                default:    wave_type = `TWM_TYPE_NORMAL;
            endcase
        end
    endfunction

    // Next value of one compare output given its mode field and events.
    function next_pin;
        input       cur;
        input [1:0] com;
        input [1:0] typ;
        input       is_a;
        input       hi;
        input       match;
        input       at_top;
        input       up;
        reg         r;
        begin
            r = cur;
            if (typ == `TWM_TYPE_NORMAL || typ == `TWM_TYPE_CTC) begin
                if (match) begin
                    case (com)
                        2'h1:    r = ~cur;
                        2'h2:    r = 1'b0;
                        2'h3:    r = 1'b1;
                        default: r = cur;
                    endcase
                end
            end else if (com == 2'h1) begin
                // Toggle only for channel A with the high mode bit set.
                if (is_a && hi && match) begin
                    r = ~cur;
                end
            end else if (com[1]) begin
                if (typ == `TWM_TYPE_FAST) begin
                    if (match) begin
                        r = ~com[0] ? 1'b0 : 1'b1;
                    end else if (at_top) begin
                        r = ~com[0] ? 1'b1 : 1'b0;
                    end
                end else if (match) begin
                    r = (up ^ com[0]) ? 1'b0 : 1'b1;
                end
            end
            next_pin = r;
        end
    endfunction

    wire [1:0] typ = wave_type(wave_gen_mode);
    wire       is_pwm = typ[1];
    // TOP source: fixed maximum or compare register A.
    wire [7:0] top = (wave_gen_mode == 3'h0 || wave_gen_mode == 3'h1 ||
                      wave_gen_mode == 3'h3) ? `TWM_MAX
                                             : compare_value_a;
    wire       at_top = (count == top);
    wire       at_max = (count == `TWM_MAX);
    wire       at_bot = (count == `TWM_BOTTOM);
    wire       hit_a = (count == compare_value_a);
    wire       hit_b = (count == compare_value_b);
    // A match at TOP is dropped when the high field bit is set in PWM.
    wire       use_a = hit_a && !(is_pwm && compare_value_a == top
                                  && cmp_out_mode_a[1]);
    wire       use_b = hit_b && !(is_pwm && compare_value_b == top
                                  && cmp_out_mode_b[1]);
    wire       wrap = (typ == `TWM_TYPE_CTC || typ == `TWM_TYPE_FAST)
                      && at_top;
    reg        ovf_evt;
    reg  [7:0] next_count;
    reg        next_dir;

    always @* begin
        next_dir = dir;
        next_count = count + 8'h01;
        case (typ)
            `TWM_TYPE_PHASE: begin
                if (dir == ST_UP) begin
                    if (at_top) begin
                        next_dir = ST_DOWN;
                        next_count = count - 8'h01;
                    end
                end else begin
                    if (at_bot) begin
                        next_dir = ST_UP;
                    end else begin
                        next_count = count - 8'h01;
                    end
                end
            end
            `TWM_TYPE_CTC, `TWM_TYPE_FAST: begin
                if (at_top) begin
                    next_count = `TWM_BOTTOM;
                end
            end
            default: next_count = count + 8'h01;
        endcase
        // Overflow flag point depends on the mode.
        case (wave_gen_mode)
            3'h1, 3'h5: ovf_evt = at_bot && dir == ST_DOWN;
            3'h7:       ovf_evt = at_top;
            3'h4, 3'h6: ovf_evt = 1'b0;
            default:    ovf_evt = at_max;
        endcase
    end

    wire       req = i_cyc && i_stb;
    wire       wr = req && i_we && i_sel[0] && !ack;
    wire       rd = req && !i_we && !ack;
    wire [5:0] reg_adr = i_adr[7:2];

    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_a <= `TWM_RESET_VAL;
            wave_gen_mode_high <= 1'b0;
            count <= `TWM_RESET_VAL;
            compare_value_a <= `TWM_RESET_VAL;
            compare_value_b <= `TWM_RESET_VAL;
            buf_cmp_a <= `TWM_RESET_VAL;
            buf_cmp_b <= `TWM_RESET_VAL;
            status <= 3'h0;
            mask <= 3'h0;
            dir <= ST_UP;
            ack <= 1'b0;
            rdat <= 32'h0;
            o_irq <= 1'b0;
            o_compare_output_a <= 1'b0;
            o_compare_output_b <= 1'b0;
            o_pin_override_a <= 1'b0;
            o_pin_override_b <= 1'b0;
        end else begin
            ack <= req && !ack;
            count <= next_count;
            dir <= next_dir;
            o_compare_output_a <= next_pin(o_compare_output_a,
                cmp_out_mode_a, typ, 1'b1, wave_gen_mode_high,
                use_a, wrap, dir == ST_UP);
            o_compare_output_b <= next_pin(o_compare_output_b,
                cmp_out_mode_b, typ, 1'b0, wave_gen_mode_high,
                use_b, wrap, dir == ST_UP);
            // The pin belongs to the compare unit once a field is nonzero.
            o_pin_override_a <= |cmp_out_mode_a;
            o_pin_override_b <= |cmp_out_mode_b;
            // Double buffering keeps PWM glitch free mid-period.
            if (!is_pwm || at_top) begin
                compare_value_a <= buf_cmp_a;
                compare_value_b <= buf_cmp_b;
            end
            if (wr) begin
                case (reg_adr)
                    `TWM_ADR_CTRL_A:
                        ctrl_a <= i_dat[7:0] & `TWM_CTRL_A_MASK;
                    `TWM_ADR_CTRL_B:
                        wave_gen_mode_high <=
                            i_dat[`TWM_WGM_HIGH_BIT];
                    `TWM_ADR_CNT: count <= i_dat[7:0];
                    `TWM_ADR_CMP_A: begin
                        buf_cmp_a <= i_dat[7:0];
                        if (!is_pwm) compare_value_a <= i_dat[7:0];
                    end
                    `TWM_ADR_CMP_B: begin
                        buf_cmp_b <= i_dat[7:0];
                        if (!is_pwm) compare_value_b <= i_dat[7:0];
                    end
                    `TWM_ADR_MASK: mask <= i_dat[2:0];
                    default: ;
                endcase
            end
            rdat <= 32'h0;
            if (rd) begin
                case (reg_adr)
                    `TWM_ADR_CTRL_A: rdat[7:0] <= ctrl_a;
                    `TWM_ADR_CTRL_B: rdat[7:0] <=
                        {4'h0, wave_gen_mode_high, 3'h0} & `TWM_CTRL_B_MASK;
                    `TWM_ADR_CNT:    rdat[7:0] <= count;
                    `TWM_ADR_CMP_A:  rdat[7:0] <= buf_cmp_a;
                    `TWM_ADR_CMP_B:  rdat[7:0] <= buf_cmp_b;
                    `TWM_ADR_STATUS: rdat[2:0] <= status;
                    `TWM_ADR_MASK:   rdat[2:0] <= mask;
                    default:         rdat <= 32'h0;
                endcase
            end
            // Events win over the read that clears them.
            status <= ((rd && reg_adr == `TWM_ADR_STATUS) ? 3'h0 : status)
                      | {hit_b, hit_a, ovf_evt};
            o_irq <= |(status & mask);
        end
    end

    assign o_ack = ack;
    assign o_dat = rdat;
endmodule
